// ### inc/bms_mem_if.sv
// carrier between the mode controller and the firmware store
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface bms_mem_if #(
  parameter int unsigned AW = 16
);
  logic wr_en; // write strobe, one cycle per byte
  logic [AW-1:0] wr_addr; // write byte address
  logic [7:0] wr_data; // write byte
  logic [AW-1:0] rd_addr; // read byte address
  logic [7:0] rd_data; // registered read byte

  modport ctl (output wr_en, output wr_addr, output wr_data,
               output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data,
               input rd_addr, output rd_data);
endinterface

// ### inc/bms_pkg.sv
// package of constants and types for the boot mode selector
// assumes a single 200 MHz clock shared by every user of these names
package bms_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000; // reference clock rate
  localparam int unsigned PWRUP_NS = 1000; // power-up strap window
  // least time, rounded up to whole cycles
  localparam int unsigned PWRUP_CYC = (PWRUP_NS * (CLK_HZ / 1_000_000)
                                       + 999) / 1000;
  localparam int unsigned BAUD_MAX = 625_000; // fastest serial rate
  // smallest bit divisor that keeps the rate at or below the maximum
  localparam int unsigned BAUD_DIV_MIN = (CLK_HZ + BAUD_MAX - 1) / BAUD_MAX;
  localparam int unsigned BAUD_DIV_W = 16; // divisor field width

  // ----------------------------------------------------------------
  // firmware store
  // ----------------------------------------------------------------
  localparam int unsigned FW_BYTES = 65536; // 64 kbyte store
  localparam int unsigned FW_AW = 16; // byte address width

  // ----------------------------------------------------------------
  // serial characters
  // ----------------------------------------------------------------
  localparam logic [7:0] CHAR_UPD = 8'h06; // update request
  localparam logic [7:0] CHAR_YES = 8'h4A; // confirm ('J')
  localparam logic [7:0] CHAR_NO = 8'h4E; // decline ('N')
  localparam logic [7:0] CHAR_QRY = 8'h3F; // confirmation query ('?')

  // ----------------------------------------------------------------
  // operating modes as shown on the mode output
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_RUN = 2'h0; // standard operation
  localparam logic [1:0] MODE_CFG = 2'h1; // configuration
  localparam logic [1:0] MODE_UPD = 2'h2; // firmware update
  localparam logic [1:0] MODE_BOOT = 2'h3; // start-up or halted

  // ----------------------------------------------------------------
  // controller states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_PWRUP = 8'h01, // strap window
    ST_SELFTEST = 8'h02, // configuration self-test
    ST_CFG_WAIT = 8'h04, // waiting for host commands
    ST_CFG_QUERY = 8'h08, // query sent, awaiting J or N
    ST_RESTART = 8'h10, // internal restart pulse
    ST_UPDATE = 8'h20, // firmware update
    ST_RUN = 8'h40, // standard operation
    ST_FAULT = 8'h80 // self-test failed, halted
  } bms_state_t;

endpackage

// ### verif/bms_host_model.sv
// host and self-test model facing the boot mode selector
// assumes one clock and the design's ready/valid transmit handshake
`timescale 1ns/1ps
module bms_host_model (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // transmit side of the design
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  // self-test engine
  input wire logic i_st_start,
  input wire logic i_st_fail,
  output logic o_st_done,
  output logic o_st_pass,
  // what the host has taken
  output logic [7:0] o_char_cnt,
  output logic [7:0] o_last_char
);
  logic [1:0] wait_r; // random stall before ready, 0..3 cycles
  logic [1:0] st_cnt_r; // self-test run time

  // ----------------------------------------------------------------
  // host receiver: stalls a little, then takes the query byte
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_ready <= 1'b0;
      wait_r <= 2'h0;
      o_char_cnt <= 8'h00;
      o_last_char <= 8'h00;
    end else begin
      o_tx_ready <= 1'b0; // ready is a one-cycle acceptance
      if (i_tx_valid && o_tx_ready) begin // byte taken
        o_char_cnt <= o_char_cnt + 8'h01;
        o_last_char <= i_tx_data;
        wait_r <= 2'($urandom_range(3, 0));
      end else if (i_tx_valid) begin
        // slow host: count the stall down before accepting
        if (wait_r == 2'h0) o_tx_ready <= 1'b1;
        else wait_r <= wait_r - 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // self-test engine: done three cycles after start, result on request
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_cnt_r <= 2'h0;
      o_st_done <= 1'b0;
      o_st_pass <= 1'b0;
    end else begin
      o_st_done <= (st_cnt_r == 2'h1);
      o_st_pass <= (st_cnt_r == 2'h1) && !i_st_fail;
      if (i_st_start) st_cnt_r <= 2'h2;
      else if (st_cnt_r != 2'h0) st_cnt_r <= st_cnt_r - 2'h1;
    end
  end
endmodule // bms_host_model

// ### verif/boot_mode_select_tb.sv
// self-checking bench for the boot mode selector
// assumes the host model file is compiled first; store shrunk to 16
`timescale 1ns/1ps
module boot_mode_select_tb;
  import bms_pkg::*;
  localparam int unsigned DEPTH = 16; // small store so full is reached
  logic clk, rst_n, boot_n, cfg_n, rx_v, tx_v, tx_rdy;
  logic st_start, st_done, st_pass, st_fail, cmd_v, usr_v;
  logic bus_en, scr_run, restart, full;
  logic [7:0] rx_d, tx_d, cmd_d, usr_d, rd_d, h_cnt, h_last, b;
  logic [15:0] baud_i, baud_o, rd_a;
  logic [1:0] mode;
  logic [7:0] mem [DEPTH]; // bytes expected in the store
  int fail_count, comparisons, n_restart, n, seed;
  int tbl [5] = '{0, 319, 320, 321, 65535}; // divisor corners

  // ----------------------------------------------------------------
  // clock, design and far side
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  bms_top #(.FW_DEPTH(DEPTH)) DUT (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_boot_strap_n(boot_n), .i_cfg_strap_n(cfg_n), .i_rx_valid(rx_v),
    .i_rx_data(rx_d), .o_tx_valid(tx_v), .o_tx_data(tx_d),
    .i_tx_ready(tx_rdy), .o_selftest_start(st_start),
    .i_selftest_done(st_done), .i_selftest_pass(st_pass),
    .o_cmd_valid(cmd_v), .o_cmd_data(cmd_d), .o_user_valid(usr_v),
    .o_user_data(usr_d), .o_bus_enable(bus_en), .o_script_run(scr_run),
    .i_baud_div(baud_i), .o_baud_div(baud_o), .o_mode(mode),
    .o_sys_restart(restart), .o_fw_full(full), .i_fw_rd_addr(rd_a),
    .o_fw_rd_data(rd_d));
  bms_host_model host (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_tx_valid(tx_v), .i_tx_data(tx_d), .o_tx_ready(tx_rdy),
    .i_st_start(st_start), .i_st_fail(st_fail), .o_st_done(st_done),
    .o_st_pass(st_pass), .o_char_cnt(h_cnt), .o_last_char(h_last));

  // restarts seen on the internal restart strobe
  always @(posedge clk) begin
    if (restart === 1'b1) n_restart++;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] f_baud(input logic [15:0] d);
    return (d < BAUD_DIV_MIN) ? 16'(BAUD_DIV_MIN) : d; // clamp at 320
  endfunction
  task automatic check(input string nm, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask
  task automatic results();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // one byte, one-cycle strobe; outputs sampled after the taking edge
  task automatic send(input logic [7:0] d);
    @(posedge clk);
    rx_v <= 1'b1;
    rx_d <= d;
    @(posedge clk);
    rx_v <= 1'b0;
    #1;
  endtask
  task automatic wait_mode(input logic [1:0] m);
    n = 0;
    while (mode !== m && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (mode !== m) begin
      check("mode wait", 16'(mode), 16'(m));
      results();
    end
  endtask
  task automatic wait_host(input logic [7:0] k);
    n = 0;
    while (h_cnt !== k && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("host chars", 16'(h_cnt), 16'(k));
    if (h_cnt !== k) results();
  endtask
  // reset, then count cycles until the mode is chosen
  task automatic do_reset(input logic b, c, input int blip,
                          input logic [1:0] m);
    rst_n <= 1'b0;
    boot_n <= b;
    cfg_n <= c;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    n = 0;
    while (n < 400) begin
      @(posedge clk);
      if (n == blip) boot_n <= 1'b1; // strap goes high here and stays high for the rest of the window
      #1;
      n++;
      if (mode !== MODE_BOOT) break;
    end
    check("window", 16'(n), 16'(PWRUP_CYC));
    check("mode", 16'(mode), 16'(m));
    if (n >= 400) results();
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, rx_v, st_fail} = 3'b000;
    {boot_n, cfg_n} = 2'b11;
    rx_d = 8'h00;
    baud_i = 16'h0000;
    rd_a = 16'h0000;
    {fail_count, comparisons, n_restart} = 0;
    seed = $urandom(52246);
    // update by strap, store filled until it refuses
    do_reset(1'b0, 1'b1, -1, MODE_UPD);
    for (int i = 0; i < DEPTH + 2; i++) begin
      b = 8'($urandom);
      if (i < DEPTH) mem[i] = b;
      send(b);
      if (i == DEPTH - 2) check("not full", 16'(full), 16'h0001 ^ 1);
      if (i == DEPTH - 1) check("full", 16'(full), 16'h0001);
    end
    for (int i = 0; i < DEPTH; i += 5) begin
      @(posedge clk);
      rd_a <= 16'(i);
      repeat (2) @(posedge clk);
      #1;
      check("store byte", 16'(rd_d), 16'(mem[i]));
    end
    // strap blip cancels update: standard operation
    do_reset(1'b0, 1'b1, 100, MODE_RUN);
    check("bus enable", 16'(bus_en), 16'h0001);
    check("script run", 16'(scr_run), 16'h0001);
    for (int i = 0; i < 6; i++) begin
      b = 8'($urandom);
      send(b);
      check("user valid", 16'(usr_v), 16'h0001);
      check("user data", 16'(usr_d), 16'(b));
    end
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      baud_i <= (i < 5) ? 16'(tbl[i]) : 16'($urandom);
      repeat (2) @(posedge clk);
      #1;
      check("baud", baud_o, f_baud(baud_i));
    end
    // configuration: self-test, commands, query, decline, confirm
    do_reset(1'b1, 1'b0, -1, MODE_CFG);
    check("self-test start", 16'(st_start), 16'h0001);
    repeat (4) @(posedge clk);
    #1;
    check("cfg after test", 16'(mode), 16'(MODE_CFG));
    check("no bus in cfg", 16'(bus_en), 16'h0000);
    send(8'h21);
    check("cmd valid", 16'(cmd_v), 16'h0001);
    check("cmd data", 16'(cmd_d), 16'h0021);
    send(CHAR_UPD);
    check("query valid", 16'(tx_v), 16'h0001);
    check("query data", 16'(tx_d), 16'(CHAR_QRY));
    wait_host(8'h01);
    check("host query", 16'(h_last), 16'(CHAR_QRY));
    send(8'h58); // host strays from J or N first
    check("stray dropped", 16'(cmd_v), 16'h0000);
    send(CHAR_NO);
    check("no restart", 16'(restart), 16'h0000);
    check("stay cfg", 16'(mode), 16'(MODE_CFG));
    send(8'h22);
    check("cmd again", 16'(cmd_v), 16'h0001);
    send(CHAR_UPD);
    wait_host(8'h02);
    send(CHAR_YES);
    check("restart", 16'(restart), 16'h0001);
    check("restart mode", 16'(mode), 16'(MODE_BOOT));
    wait_mode(MODE_UPD);
    check("one restart", 16'(n_restart), 16'h0001);
    // failing self-test halts, host commands refused
    st_fail <= 1'b1;
    do_reset(1'b1, 1'b0, -1, MODE_CFG);
    repeat (6) @(posedge clk);
    #1;
    check("fault", 16'(mode), 16'(MODE_BOOT));
    send(CHAR_UPD);
    check("no query", 16'(tx_v), 16'h0000);
    results();
  end

  // hang guard
  initial begin
    #400000;
    fail_count++;
    results();
  end
endmodule // boot_mode_select_tb

// ### verilog/bms_fw_mem.sv
// firmware store: byte wide, one write and one registered read port
// assumes the controller gives at most one write per cycle
`timescale 1ns/1ps
module bms_fw_mem #(
  parameter int unsigned DEPTH = 65536,
  parameter int unsigned AW = 16
) (
  // clock
  input wire logic i_ref_clk,
  // controller side
  bms_mem_if.mem mif
);
  import bms_pkg::*;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  localparam int unsigned IW = $clog2(DEPTH); // index bits in use
  // a power of two that the address bus can reach
  localparam bit DEPTH_OK = (DEPTH >= 2) && (DEPTH <= (1 << AW))
                            && ((DEPTH & (DEPTH - 1)) == 0);
  if (!DEPTH_OK) begin : g_bad_depth
    $error("bms_fw_mem: depth must be a power of two within 2**AW");
  end

  logic [7:0] store_r [DEPTH]; // array, no reset: contents survive
  logic [7:0] rd_data_r; // read data flop

  // ----------------------------------------------------------------
  // write and registered read
  // ----------------------------------------------------------------
  // read returns the old byte on a same-address write
  always_ff @(posedge i_ref_clk) begin
    if (mif.wr_en) begin
      store_r[mif.wr_addr[IW-1:0]] <= mif.wr_data; // RULE1
    end
    rd_data_r <= store_r[mif.rd_addr[IW-1:0]];
  end

  assign mif.rd_data = rd_data_r;

endmodule // bms_fw_mem

// ### verilog/bms_top.sv
// boot mode selector: start-up mode choice and update entry
// assumes serial bytes arrive already deframed, one per valid cycle
// Behaviour
// RULE1 - 64 kbyte store, filled only from serial
// RULE2 - strap low through power-up forces update
// RULE3 - 0x06 in configuration sends confirmation query
// RULE4 - only J or N answer the query
// RULE5 - J restarts into update mode
// RULE6 - configuration entry runs self-test first
// RULE7 - after passing self-test, accept host commands
// RULE8 - standard mode runs scripts, data, fieldbus
// RULE9 - baud up to 625 Kbaud, script selected
// RULE10 - N keeps configuration mode, no restart
`timescale 1ns/1ps
module bms_top #(
  parameter int unsigned FW_DEPTH = bms_pkg::FW_BYTES
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // straps
  input wire logic i_boot_strap_n,
  input wire logic i_cfg_strap_n,
  // serial byte stream
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  input wire logic i_tx_ready,
  // self-test engine
  output logic o_selftest_start,
  input wire logic i_selftest_done,
  input wire logic i_selftest_pass,
  // configuration commands to the script loader
  output logic o_cmd_valid,
  output logic [7:0] o_cmd_data,
  // standard operation
  output logic o_user_valid,
  output logic [7:0] o_user_data,
  output logic o_bus_enable,
  output logic o_script_run,
  // baud selection
  input wire logic [bms_pkg::BAUD_DIV_W-1:0] i_baud_div,
  output logic [bms_pkg::BAUD_DIV_W-1:0] o_baud_div,
  // status and firmware readback
  output logic [1:0] o_mode,
  output logic o_sys_restart,
  output logic o_fw_full,
  input wire logic [bms_pkg::FW_AW-1:0] i_fw_rd_addr,
  output logic [7:0] o_fw_rd_data
);
  import bms_pkg::*;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // smaller stores serve short test runs; the default is the full size
  localparam bit DEPTH_OK = (FW_DEPTH >= 2) && (FW_DEPTH <= FW_BYTES)
                            && ((FW_DEPTH & (FW_DEPTH - 1)) == 0);
  if (!DEPTH_OK) begin : g_bad_depth
    $error("bms_top: store depth must be a power of two up to 64 kbyte");
  end

  localparam logic [15:0] PWRUP_LAST = 16'(PWRUP_CYC - 1); // last count
  localparam logic [BAUD_DIV_W-1:0] DIV_MIN = BAUD_DIV_W'(BAUD_DIV_MIN);
  localparam logic [FW_AW-1:0] FW_LAST = FW_AW'(FW_DEPTH - 1); // last byte

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bms_state_t state_r, state_nxt; // controller state
  logic [15:0] pw_cnt_r; // power-up window counter
  logic strap_low_r; // strap held low so far in window
  logic upd_pend_r; // restart-into-update request, kept over restart
  logic [FW_AW-1:0] wr_addr_r; // next store byte address
  logic full_r; // store filled
  logic tx_valid_r; // query pending on serial
  logic [7:0] tx_data_r; // transmit byte
  logic cmd_valid_r; // command byte strobe
  logic [7:0] cmd_data_r; // command byte
  logic user_valid_r; // user byte strobe
  logic [7:0] user_data_r; // user byte
  logic st_start_r; // self-test start pulse
  logic [BAUD_DIV_W-1:0] baud_r; // clamped divisor

  bms_mem_if #(.AW(FW_AW)) mif (); // store carrier

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire pw_end = (state_r == ST_PWRUP) && (pw_cnt_r == PWRUP_LAST);
  wire strap_low_all = strap_low_r && !i_boot_strap_n; // RULE2
  wire rx_upd = i_rx_valid && (i_rx_data == CHAR_UPD);
  wire rx_yes = i_rx_valid && (i_rx_data == CHAR_YES);
  wire rx_no = i_rx_valid && (i_rx_data == CHAR_NO);
  // only serial bytes in update mode reach the store
  wire fw_wr = (state_r == ST_UPDATE) && i_rx_valid && !full_r; // RULE1
  // too fast a request is held at the fastest legal rate
  wire [BAUD_DIV_W-1:0] baud_nxt = (i_baud_div < DIV_MIN) ? DIV_MIN
                                   : i_baud_div; // RULE9

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_PWRUP: begin
        if (pw_end) begin
          if (strap_low_all || upd_pend_r) begin
            state_nxt = ST_UPDATE; // RULE2 RULE5
          end else if (!i_cfg_strap_n) begin
            state_nxt = ST_SELFTEST; // RULE6
          end else begin
            state_nxt = ST_RUN;
          end
        end
      end
      ST_SELFTEST: begin
        // commands wait until the self-test passes
        if (i_selftest_done) begin
          state_nxt = i_selftest_pass ? ST_CFG_WAIT : ST_FAULT; // RULE7
        end
      end
      ST_CFG_WAIT: begin
        if (rx_upd) begin
          state_nxt = ST_CFG_QUERY; // RULE3
        end
      end
      ST_CFG_QUERY: begin
        // any byte other than J or N leaves the query open
        if (rx_yes) begin
          state_nxt = ST_RESTART; // RULE4 RULE5
        end else if (rx_no) begin
          state_nxt = ST_CFG_WAIT; // RULE4 RULE10
        end
      end
      ST_RESTART: state_nxt = ST_PWRUP; // RULE5
      ST_UPDATE: state_nxt = ST_UPDATE;
      ST_RUN: state_nxt = ST_RUN;
      ST_FAULT: state_nxt = ST_FAULT;
      default: state_nxt = ST_PWRUP;
    endcase
  end

  // ----------------------------------------------------------------
  // state register and power-up window
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_PWRUP;
      pw_cnt_r <= 16'h0000;
      strap_low_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      // counter restarts with each power-up window
      pw_cnt_r <= (state_r == ST_PWRUP) ? pw_cnt_r + 16'h0001 : 16'h0000;
      // one high sample anywhere in the window cancels the strap
      strap_low_r <= (state_r == ST_PWRUP) ? strap_low_all : 1'b1; // RULE2
    end
  end

  // ----------------------------------------------------------------
  // update request: survives the internal restart
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      upd_pend_r <= 1'b0;
    end else if ((state_r == ST_CFG_QUERY) && rx_yes) begin
      upd_pend_r <= 1'b1; // RULE5
    end else if (state_r == ST_UPDATE) begin
      upd_pend_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // store write address
  // ----------------------------------------------------------------
  // saturates: bytes past the store's end are dropped, never wrapped
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_addr_r <= '0;
      full_r <= 1'b0;
    end else if (fw_wr) begin
      wr_addr_r <= wr_addr_r + 1'b1; // RULE1
      full_r <= (wr_addr_r == FW_LAST);
    end
  end

  // ----------------------------------------------------------------
  // query transmit: byte stands until taken
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_valid_r <= 1'b0;
      tx_data_r <= 8'h00;
    end else if ((state_r == ST_CFG_WAIT) && rx_upd) begin
      tx_valid_r <= 1'b1; // RULE3
      tx_data_r <= CHAR_QRY;
    end else if (i_tx_ready) begin
      tx_valid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // byte routing to loader and user side, self-test start, baud
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmd_valid_r <= 1'b0;
      cmd_data_r <= 8'h00;
      user_valid_r <= 1'b0;
      user_data_r <= 8'h00;
      st_start_r <= 1'b0;
      baud_r <= DIV_MIN;
    end else begin
      // in command wait, bytes other than the update request go to the script loader
      cmd_valid_r <= (state_r == ST_CFG_WAIT) && i_rx_valid
                     && !rx_upd; // RULE7
      user_valid_r <= (state_r == ST_RUN) && i_rx_valid; // RULE8
      if (i_rx_valid) begin
        cmd_data_r <= i_rx_data;
        user_data_r <= i_rx_data;
      end
      st_start_r <= pw_end && (state_nxt == ST_SELFTEST); // RULE6
      baud_r <= baud_nxt; // RULE9
    end
  end

  // ----------------------------------------------------------------
  // firmware store
  // ----------------------------------------------------------------
  assign mif.wr_en = fw_wr;
  assign mif.wr_addr = wr_addr_r;
  assign mif.wr_data = i_rx_data;
  assign mif.rd_addr = i_fw_rd_addr;

  bms_fw_mem #(.DEPTH(FW_DEPTH), .AW(FW_AW)) u_mem (
    .i_ref_clk(i_ref_clk),
    .mif(mif.mem)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  wire in_cfg = (state_r == ST_SELFTEST) || (state_r == ST_CFG_WAIT)
                || (state_r == ST_CFG_QUERY);
  assign o_mode = (state_r == ST_RUN) ? MODE_RUN
                : in_cfg ? MODE_CFG
                : (state_r == ST_UPDATE) ? MODE_UPD : MODE_BOOT;
  assign o_tx_valid = tx_valid_r;
  assign o_tx_data = tx_data_r;
  assign o_selftest_start = st_start_r;
  assign o_cmd_valid = cmd_valid_r;
  assign o_cmd_data = cmd_data_r;
  assign o_user_valid = user_valid_r;
  assign o_user_data = user_data_r;
  assign o_bus_enable = (state_r == ST_RUN); // RULE8
  assign o_script_run = (state_r == ST_RUN); // RULE8
  assign o_baud_div = baud_r;
  assign o_sys_restart = (state_r == ST_RESTART); // RULE5
  assign o_fw_full = full_r;
  assign o_fw_rd_data = mif.rd_data;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  AST_STRAP_UPDATE: assert property ( // RULE2
    pw_end && strap_low_all |=> state_r == ST_UPDATE && o_mode == MODE_UPD)
    else $error("strap low in window did not give update mode");
  AST_FW_ONLY_UPDATE: assert property ( // RULE1
    mif.wr_en |-> state_r == ST_UPDATE && i_rx_valid)
    else $error("store written outside update mode");
  AST_QUERY_REPLY: assert property ( // RULE3
    state_r == ST_CFG_WAIT && rx_upd
    |=> o_tx_valid && o_tx_data == CHAR_QRY && state_r == ST_CFG_QUERY)
    else $error("update request not answered by query");
  AST_OTHER_IGNORED: assert property ( // RULE4
    state_r == ST_CFG_QUERY && !rx_yes && !rx_no |=> state_r == ST_CFG_QUERY)
    else $error("query left without J or N");
  AST_YES_RESTART: assert property ( // RULE5
    state_r == ST_CFG_QUERY && rx_yes
    |=> o_sys_restart ##1 state_r == ST_PWRUP && upd_pend_r)
    else $error("yes did not restart toward update");
  AST_SELFTEST_FIRST: assert property ( // RULE6
    $rose(state_r == ST_SELFTEST) |-> o_selftest_start && !o_cmd_valid)
    else $error("configuration entered without self-test");
  AST_PASS_WAIT: assert property ( // RULE7
    state_r == ST_SELFTEST && i_selftest_done && i_selftest_pass
    |=> state_r == ST_CFG_WAIT)
    else $error("passing self-test did not open command wait");
  AST_RUN_DATA: assert property ( // RULE8
    state_r == ST_RUN && i_rx_valid
    |=> o_user_valid && o_user_data == $past(i_rx_data) && o_bus_enable)
    else $error("standard mode byte not passed on");
  AST_BAUD_LIMIT: assert property ( // RULE9
    o_baud_div >= DIV_MIN)
    else $error("baud divisor above 625 Kbaud rate");
  AST_NO_STAYS: assert property ( // RULE10
    state_r == ST_CFG_QUERY && rx_no
    |=> state_r == ST_CFG_WAIT ##1 o_mode == MODE_CFG && !o_sys_restart)
    else $error("no reply did not return to command wait");

  COV_STRAP_UPDATE: cover property (pw_end && strap_low_all);
  COV_SOFT_UPDATE: cover property (
    o_sys_restart ##[1:300] state_r == ST_UPDATE);
  COV_NO_REPLY: cover property (state_r == ST_CFG_QUERY && rx_no);
  COV_RUN_MODE: cover property (o_user_valid);

endmodule // bms_top
